// >>> cable_partner.sv
// Twisted-pair link partner model on the PHY line side
`timescale 1ns/1ps
`default_nettype none
module cable_partner
#(
    parameter int LINK_DELAY = 6
)(
    input  wire logic       core_clk_i,
    input  wire logic [1:0] plug_i,
    output var  logic [1:0] energy_o,
    output var  logic [1:0] link_o
);
    int cnt_q [2] = '{0, 0};
    // Link only follows energy after a delay, never leads it
    always_ff @(posedge core_clk_i)
    begin
        for (int p = 0; p < 2; p++)
        begin
            cnt_q[p] <= plug_i[p] ? cnt_q[p] + 1 : 0;
        end
    end
    always_comb
    begin
        energy_o = plug_i;
        for (int p = 0; p < 2; p++)
        begin
            link_o[p] = cnt_q[p] > LINK_DELAY;
        end
    end
endmodule : cable_partner
`default_nettype wire

// >>> link_pulse_gen.sv
// Periodic link pulse generator for energy detect mode
`timescale 1ns/1ps
`default_nettype none
module link_pulse_gen
    import pwr_mode_pkg::*;
#(
    parameter int PERIOD_CYCLES = PULSE_PERIOD_CYCLES,
    parameter int WIDTH_CYCLES  = PULSE_CYCLES
)(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    output var  logic pulse_o
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    wire         wrap = (cnt_q == 32'(PERIOD_CYCLES - 1));
    assign cnt_d = (!enable_i || wrap) ? 32'h0 : cnt_q + 32'h1;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q   <= 32'h0;
            pulse_o <= 1'b0;
        end
        else
        begin
            cnt_q   <= cnt_d;
            // Count before it advances, so the first pulse after enable is full width too
            pulse_o <= enable_i && (cnt_q < 32'(WIDTH_CYCLES)); // [R11]
        end
    end

    AST_PULSE_WIDTH: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R11]
        (enable_i && cnt_q == 32'h0) |=> pulse_o)
        else $error("pulse missing at period start");
endmodule : link_pulse_gen
`default_nettype wire

// >>> phy_power_mode_control.sv
// PHY power mode controller with host register access
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Mode field 00 normal, 01 energy detect, 10 soft power down, 11 power saving.
// [R2] Port PHY control bit 3 powers that PHY down regardless of mode.
// [R3] Mode field resets to 00, normal operation.
// [R4] Normal mode: PLL, PHY, MAC and host interface all enabled.
// [R5] Host leaves normal mode by writing another mode code.
// [R6] Power saving only with autoneg on, cable out and mode 11.
// [R7] Power saving keeps PLL, MAC, host; PHY transmits, unused receiver off.
// [R8] Line activity during power saving restores full PHY power.
// [R9] Energy detect has normal and low power states; low keeps only energy detect.
// [R10] Go to low power after no energy longer than go-sleep delay.
// [R11] Energy detect without link sends 120 ns pulse each second.
// [R12] Low power keeps watching energy; energy returns to normal power.
// [R13] Soft power down stops PLL, PHY and MAC, keeps registers.
// [R14] Writing 00 ends soft power down, back to normal.
// [R15] Power mode bit 2 disables PLL; the code applies it in energy detect mode only.
// [R16] Chip power-down pin low powers down the whole device.
// [R17] Mode writes take effect at once and persist until rewritten or reset.
module phy_power_mode_control
    import pwr_mode_pkg::*;
#(
    parameter int NUM_PORTS   = 2,
    parameter int SLEEP_TICK  = SLEEP_TICK_CYCLES,
    parameter int PULSE_PER   = PULSE_PERIOD_CYCLES
)(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output var  logic [7:0]           reg_rdata_o,
    input  wire logic                 chip_power_down_n_i,
    input  wire logic [NUM_PORTS-1:0] energy_det_i,
    input  wire logic [NUM_PORTS-1:0] link_up_i,
    input  wire logic [NUM_PORTS-1:0] autoneg_en_i,
    output var  logic                 pll_en_o,
    output var  logic                 mac_en_o,
    output var  logic                 host_if_en_o,
    output var  logic [NUM_PORTS-1:0] phy_tx_en_o,
    output var  logic [NUM_PORTS-1:0] phy_rx_en_o,
    output var  logic [NUM_PORTS-1:0] phy_edet_en_o,
    output var  logic [NUM_PORTS-1:0] link_pulse_o,
    output var  logic                 chip_off_o,
    output var  logic [1:0]           ed_state_o
);
    logic [1:0]           pd_meta_q;
    logic [NUM_PORTS-1:0] en_meta_q;
    logic [NUM_PORTS-1:0] en_sync_q;
    logic [NUM_PORTS-1:0] lk_meta_q;
    logic [NUM_PORTS-1:0] lk_sync_q;
    logic [NUM_PORTS-1:0] an_meta_q;
    logic [NUM_PORTS-1:0] an_sync_q;
    logic                 pd_n_q;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pd_meta_q <= 2'h3;
            en_meta_q <= '0;
            en_sync_q <= '0;
            lk_meta_q <= '0;
            lk_sync_q <= '0;
            an_meta_q <= '0;
            an_sync_q <= '0;
        end
        else
        begin
            pd_meta_q <= {pd_meta_q[0], chip_power_down_n_i};
            en_meta_q <= energy_det_i;
            en_sync_q <= en_meta_q;
            lk_meta_q <= link_up_i;
            lk_sync_q <= lk_meta_q;
            an_meta_q <= autoneg_en_i;
            an_sync_q <= an_meta_q;
        end
    end
    assign pd_n_q = pd_meta_q[1];

    // Registers
    logic [7:0] phy_ctrl_q [NUM_PORTS];
    logic [7:0] power_mode_q;
    logic [7:0] sleep_delay_q;
    wire        sel_pm  = (reg_addr_i == OFS_POWER_MODE_CTRL);
    wire        sel_sd  = (reg_addr_i == OFS_SLEEP_DELAY_CFG);
    wire  [7:0] port_ofs [NUM_PORTS];
    assign port_ofs[0] = OFS_PORT1_PHY_CTRL;
    assign port_ofs[1] = OFS_PORT2_PHY_CTRL;

    wire [1:0] mode    = power_mode_q[1:0]; // [R1]
    wire       pll_dis = power_mode_q[PLL_DIS_BIT]; // [R15]
    // Host interface is shut while the power-down pin is low; no write may reach it
    wire       wr_ok   = reg_wr_i && pd_n_q;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            power_mode_q  <= RST_POWER_MODE; // [R3]
            sleep_delay_q <= RST_SLEEP_DELAY;
        end
        else
        begin
            if (wr_ok && sel_pm)
                power_mode_q <= reg_wdata_i; // [R5] [R14] [R17]
            if (wr_ok && sel_sd && mode != MODE_SOFT_PD)
                sleep_delay_q <= reg_wdata_i;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port_reg
            always_ff @(posedge core_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    phy_ctrl_q[gp] <= RST_PHY_CTRL;
                else if (wr_ok && reg_addr_i == port_ofs[gp] && mode != MODE_SOFT_PD)
                    phy_ctrl_q[gp] <= reg_wdata_i;
            end
        end
    endgenerate

    logic [7:0] rdata_d;
    always_comb
    begin
        rdata_d = 8'h00;
        if (sel_pm)
            rdata_d = power_mode_q;
        else if (sel_sd)
            rdata_d = sleep_delay_q;
        else if (reg_addr_i == port_ofs[0])
            rdata_d = phy_ctrl_q[0];
        else if (reg_addr_i == port_ofs[1])
            rdata_d = phy_ctrl_q[1];
    end

    // Energy detect sleep timer: delay field counts ticks of SLEEP_TICK cycles
    ed_state_t  ed_q;
    ed_state_t  ed_d;
    logic [31:0] tick_q;
    logic [8:0]  idle_q;
    wire         any_energy = |en_sync_q;
    wire         in_ed      = (mode == MODE_ENERGY) && pd_n_q;
    wire         tick       = (tick_q == 32'(SLEEP_TICK - 1));
    wire         idle_over  = (idle_q > {1'b0, sleep_delay_q}); // [R10]

    always_comb
    begin
        ed_d = ed_q;
        case (ed_q)
            ED_NORMAL:
            begin
                if (in_ed && !any_energy && idle_over) // [R10]
                    ed_d = ED_LOW;
            end
            ED_LOW:
            begin
                if (!in_ed || any_energy) // [R12]
                    ed_d = ED_NORMAL;
            end
            default:
            begin
                ed_d = ED_NORMAL;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ed_q   <= ED_NORMAL;
            tick_q <= 32'h0;
            idle_q <= 9'h0;
        end
        else
        begin
            ed_q   <= ed_d;
            tick_q <= (!in_ed || any_energy || tick) ? 32'h0 : tick_q + 32'h1;
            if (!in_ed || any_energy)
                idle_q <= 9'h0;
            else if (tick && !idle_q[8])
                idle_q <= idle_q + 9'h1;
        end
    end

    wire ed_low = in_ed && (ed_q == ED_LOW);
    wire pulse_en = in_ed && !(|lk_sync_q); // [R11]

    // Power saving needs autoneg on and cable out; activity wakes the receiver
    wire ps_mode = (mode == MODE_PWR_SAVE) && pd_n_q;
    wire [NUM_PORTS-1:0] ps_rx_off = {NUM_PORTS{ps_mode}} & an_sync_q & ~lk_sync_q & ~en_sync_q; // [R6] [R8]
    wire soft_pd = (mode == MODE_SOFT_PD) || !pd_n_q; // [R13] [R16]

    wire pll_on  = pd_n_q && (mode != MODE_SOFT_PD) && !(pll_dis && in_ed) && !ed_low; // [R4] [R13] [R15]
    wire mac_on  = pd_n_q && (mode != MODE_SOFT_PD) && !ed_low; // [R7] [R9]
    wire [NUM_PORTS-1:0] port_pd;
    wire [NUM_PORTS-1:0] pulse_w;

    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            assign port_pd[gp] = phy_ctrl_q[gp][PHY_PD_BIT] || soft_pd; // [R2]
            link_pulse_gen #(
                .PERIOD_CYCLES (PULSE_PER),
                .WIDTH_CYCLES  (PULSE_CYCLES)
            ) u_pulse (
                .core_clk_i (core_clk_i),
                .rst_i      (rst_i),
                .enable_i   (pulse_en && !port_pd[gp]),
                .pulse_o    (pulse_w[gp])
            );
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o   <= 8'h00;
            pll_en_o      <= 1'b1;
            mac_en_o      <= 1'b1;
            host_if_en_o  <= 1'b1;
            phy_tx_en_o   <= '1;
            phy_rx_en_o   <= '1;
            phy_edet_en_o <= '1;
            link_pulse_o  <= '0;
            chip_off_o    <= 1'b0;
            ed_state_o    <= 2'h0;
        end
        else
        begin
            reg_rdata_o   <= (reg_rd_i && pd_n_q) ? rdata_d : 8'h00;
            pll_en_o      <= pll_on;
            mac_en_o      <= mac_on;
            host_if_en_o  <= pd_n_q && !ed_low;
            phy_tx_en_o   <= ~port_pd & {NUM_PORTS{!ed_low}};          // [R7] [R9]
            phy_rx_en_o   <= ~port_pd & ~ps_rx_off & {NUM_PORTS{!ed_low}}; // [R7] [R8]
            phy_edet_en_o <= ~port_pd;                                  // [R9] [R12]
            link_pulse_o  <= pulse_w;
            chip_off_o    <= !pd_n_q;                                   // [R16]
            ed_state_o    <= ed_low ? 2'h1 : 2'h0;
        end
    end

    AST_MODE_RESET: assert property (@(posedge core_clk_i) // [R3]
        $fell(rst_i) |-> (power_mode_q[1:0] == MODE_NORMAL))
        else $error("mode not normal after reset");
    AST_MODE_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R17]
        (wr_ok && sel_pm) |=> (power_mode_q == $past(reg_wdata_i)))
        else $error("mode write not applied");
    AST_PORT_PD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R2]
        phy_ctrl_q[0][PHY_PD_BIT] |=> !phy_tx_en_o[0] && !phy_rx_en_o[0])
        else $error("port power down ignored");
    AST_SOFT_PD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R13]
        (mode == MODE_SOFT_PD) |=> !pll_en_o && !mac_en_o && phy_tx_en_o == '0)
        else $error("soft power down leaves blocks on");
    AST_NORMAL: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R4]
        (mode == MODE_NORMAL && pd_n_q && phy_ctrl_q[0] == 8'h00) |=> pll_en_o && mac_en_o && phy_rx_en_o[0])
        else $error("normal mode not fully on");
    AST_PIN_PD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
        !pd_n_q |=> chip_off_o && !pll_en_o && !host_if_en_o)
        else $error("hardware power down ignored");
    AST_PS_KEEP: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R7]
        ps_mode |=> pll_en_o && mac_en_o && host_if_en_o)
        else $error("power saving stopped core");
    sequence s_low;
        in_ed && ed_q == ED_LOW;
    endsequence
    AST_ED_WAKE: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R12]
        s_low ##0 any_energy |=> (ed_q == ED_NORMAL) ##1 mac_en_o)
        else $error("energy did not wake");
    AST_ED_SLEEP: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R10]
        (ed_q == ED_NORMAL && in_ed && !any_energy && idle_over) |=> s_low)
        else $error("did not enter low power");
    AST_PS_WAKE: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R8]
        (ps_mode && en_sync_q[0] && !phy_ctrl_q[0][PHY_PD_BIT]) |=> phy_rx_en_o[0])
        else $error("activity did not restore receiver");

    // Gating checks per mode; each looks one edge after its cause, the link pulse check two
    AST_PS_GATE: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R6]
        (ps_mode && !an_sync_q[0] && !phy_ctrl_q[0][PHY_PD_BIT]) |=> phy_rx_en_o[0])
        else $error("receiver off without autoneg");
    AST_PS_RX_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R6]
        (ps_mode && an_sync_q[0] && !lk_sync_q[0] && !en_sync_q[0]) |=> !phy_rx_en_o[0])
        else $error("idle receiver left on in power saving");
    AST_PS_TX_ON: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R7]
        (ps_mode && !phy_ctrl_q[0][PHY_PD_BIT]) |=> phy_tx_en_o[0])
        else $error("transmitter off in power saving");
    AST_PS_READ: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R7]
        (ps_mode && reg_rd_i && sel_pm) |=> (reg_rdata_o == $past(power_mode_q)))
        else $error("register read lost in power saving");
    AST_ED_LOW_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R9]
        s_low |=> !pll_en_o && !mac_en_o && !host_if_en_o && phy_tx_en_o == '0 && phy_rx_en_o == '0)
        else $error("low power state left blocks on");
    AST_ED_EDET: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R9]
        s_low ##0 !phy_ctrl_q[0][PHY_PD_BIT] |=> phy_edet_en_o[0])
        else $error("energy detector off in low power");
    AST_ED_STATE_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R9]
        !in_ed |=> (ed_state_o == 2'h0))
        else $error("low power state shown outside energy detect");
    AST_ED_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R10]
        (ed_q == ED_NORMAL && !idle_over) |=> (ed_q == ED_NORMAL))
        else $error("low power entered before go-sleep delay");
    sequence s_no_pulse;
        !pulse_en ##1 !pulse_en;
    endsequence
    AST_PULSE_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R11]
        s_no_pulse |=> (link_pulse_o == '0))
        else $error("link pulse outside energy detect");
    AST_SD_KEEP: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R13]
        (wr_ok && sel_sd && mode == MODE_SOFT_PD) |=> $stable(sleep_delay_q))
        else $error("delay register changed in soft power down");
    AST_CTRL_KEEP: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R13]
        (wr_ok && reg_addr_i == port_ofs[0] && mode == MODE_SOFT_PD) |=> $stable(phy_ctrl_q[0]))
        else $error("port control changed in soft power down");
    sequence s_exit_soft;
        (mode == MODE_SOFT_PD) ##0 (wr_ok && sel_pm && reg_wdata_i[1:0] == MODE_NORMAL);
    endsequence
    AST_SOFT_EXIT: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R14]
        s_exit_soft |=> (mode == MODE_NORMAL))
        else $error("soft power down not left");
    AST_PLL_DIS: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R15]
        (in_ed && pll_dis) |=> !pll_en_o)
        else $error("pll still on with disable bit");
    AST_PIN_WR: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
        (!pd_n_q && reg_wr_i) |=> $stable(power_mode_q))
        else $error("write taken during hardware power down");
    AST_PIN_RD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
        !pd_n_q |=> (reg_rdata_o == 8'h00))
        else $error("read data during hardware power down");
    AST_CHIP_ON: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
        pd_n_q |=> !chip_off_o)
        else $error("power down flag without pin");
    AST_MODE_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R17]
        !(wr_ok && sel_pm) |=> $stable(power_mode_q))
        else $error("mode changed without a write");
    AST_PORT2_PD: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R2]
        phy_ctrl_q[1][PHY_PD_BIT] |=> !phy_tx_en_o[1] && !phy_edet_en_o[1])
        else $error("second port power down ignored");
endmodule : phy_power_mode_control
`default_nettype wire

// >>> pwr_mode_pkg.sv
// Constants and types for the PHY power mode controller
package pwr_mode_pkg;
    localparam logic [7:0] OFS_PORT1_PHY_CTRL  = 8'h1d;
    localparam logic [7:0] OFS_PORT2_PHY_CTRL  = 8'h2d;
    localparam logic [7:0] OFS_POWER_MODE_CTRL = 8'hc3;
    localparam logic [7:0] OFS_SLEEP_DELAY_CFG = 8'hc4;
    localparam int PHY_PD_BIT      = 3;
    localparam int PLL_DIS_BIT     = 2;
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_ENERGY   = 2'h1;
    localparam logic [1:0] MODE_SOFT_PD  = 2'h2;
    localparam logic [1:0] MODE_PWR_SAVE = 2'h3;
    localparam logic [7:0] RST_PHY_CTRL    = 8'h00;
    localparam logic [7:0] RST_POWER_MODE  = 8'h00;
    localparam logic [7:0] RST_SLEEP_DELAY = 8'h50;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int PULSE_WIDTH_NS  = 120;
    localparam int PULSE_CYCLES    = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_PERIOD_NS = 1000000000;
    localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SLEEP_TICK_CYCLES   = 250000;
    typedef enum logic [1:0] {
        ED_NORMAL = 2'b01,
        ED_LOW    = 2'b10
    } ed_state_t;
endpackage : pwr_mode_pkg

// >>> testbench.sv
// Self-checking bench for the PHY power mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pwr_mode_pkg::*;
;
    logic       core_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic       pin_n = 1'b1;
    logic [1:0] plug = 2'b00;
    logic [1:0] autoneg = 2'b11;
    logic [7:0] reg_rdata_o;
    logic       pll_en_o, mac_en_o, host_if_en_o, chip_off_o;
    logic [1:0] tx_en, rx_en, edet_en, pulse, ed_state, energy, link;
    // Status byte: pll mac host tx[1:0] rx[1:0] off
    wire  [7:0] st = {pll_en_o, mac_en_o, host_if_en_o, tx_en, rx_en, chip_off_o};
    int         errors = 0;
    int         checked = 0;

    cable_partner line_partner (.core_clk_i(core_clk_i), .plug_i(plug), .energy_o(energy), .link_o(link));
    // Short tick and period keep the run brief
    phy_power_mode_control #(.SLEEP_TICK(4), .PULSE_PER(100)) DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .chip_power_down_n_i(pin_n),
        .energy_det_i(energy), .link_up_i(link), .autoneg_en_i(autoneg), .pll_en_o(pll_en_o),
        .mac_en_o(mac_en_o), .host_if_en_o(host_if_en_o), .phy_tx_en_o(tx_en), .phy_rx_en_o(rx_en),
        .phy_edet_en_o(edet_en), .link_pulse_o(pulse), .chip_off_o(chip_off_o), .ed_state_o(ed_state));

    initial
    begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        cyc(1);
        reg_wr_i = 1'b0;
        // Idle cycle so a following call never re-raises the strobe in one step
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        cyc(1);
        reg_rd_i = 1'b0;
        check(reg_rdata_o, exp);
        cyc(1);
    endtask : rd

    task automatic wait_ed(input logic [1:0] want);
        int n;
        n = 0;
        while (ed_state !== want)
        begin
            n++;
            if (n > 60)
            begin
                errors++;
                $display("ERROR %0t energy detect state wait ran out", $time);
                complete_run();
            end
            cyc(1);
        end
    endtask : wait_ed

    task automatic t_reset();
        check(st, 8'hfe);
        rd(OFS_POWER_MODE_CTRL, 8'h00);
        rd(OFS_SLEEP_DELAY_CFG, RST_SLEEP_DELAY);
        rd(8'h00, 8'h00);
    endtask : t_reset

    task automatic t_port_pd();
        wr(OFS_PORT1_PHY_CTRL, 8'h08);
        cyc(3);
        check(st, 8'hf4);
        rd(OFS_PORT1_PHY_CTRL, 8'h08);
        wr(OFS_PORT1_PHY_CTRL, 8'h00);
        wr(OFS_PORT2_PHY_CTRL, 8'h08);
        cyc(3);
        check(st, 8'hea);
        check({6'h00, edet_en}, 8'h01);
        wr(OFS_PORT2_PHY_CTRL, 8'h00);
        cyc(3);
        check(st, 8'hfe);
    endtask : t_port_pd

    task automatic t_soft_pd();
        wr(OFS_SLEEP_DELAY_CFG, 8'h02);
        wr(OFS_POWER_MODE_CTRL, {6'h00, MODE_SOFT_PD});
        cyc(3);
        check(st & 8'hdf, 8'h00);
        wr(OFS_PORT1_PHY_CTRL, 8'h08);
        wr(OFS_SLEEP_DELAY_CFG, 8'h07);
        wr(OFS_POWER_MODE_CTRL, {6'h00, MODE_NORMAL});
        cyc(3);
        check(st, 8'hfe);
        rd(OFS_SLEEP_DELAY_CFG, 8'h02);
        rd(OFS_PORT1_PHY_CTRL, 8'h00);
    endtask : t_soft_pd

    task automatic t_energy();
        int n;
        n = 0;
        wr(OFS_POWER_MODE_CTRL, {6'h00, MODE_ENERGY});
        cyc(8);
        check({6'h00, ed_state}, 8'h00);
        wait_ed(2'b01);
        check(st & 8'h58, 8'h00);
        check({6'h00, edet_en}, 8'h03);
        // Any 100-cycle span holds exactly one pulse width of high cycles, PULSE_CYCLES in all
        repeat (100)
        begin
            cyc(1);
            n += int'(pulse[0]);
        end
        check(8'(n), 8'(PULSE_CYCLES));
        plug = 2'b11;
        wait_ed(2'b00);
        cyc(2);
        check(st & 8'h58, 8'h58);
        // PLL bit checked in the normal power state, where nothing else stops the PLL
        wr(OFS_POWER_MODE_CTRL, 8'h05);
        cyc(3);
        check(st & 8'hd8, 8'h58);
        wr(OFS_POWER_MODE_CTRL, 8'h01);
        cyc(3);
        check(st & 8'hd8, 8'hd8);
        plug = 2'b00;
        wr(OFS_POWER_MODE_CTRL, 8'h00);
    endtask : t_energy

    task automatic t_pwr_save();
        autoneg = 2'b00;
        wr(OFS_POWER_MODE_CTRL, {6'h00, MODE_PWR_SAVE});
        cyc(5);
        check(st, 8'hfe);
        autoneg = 2'b11;
        cyc(5);
        check(st, 8'hf8);
        rd(OFS_POWER_MODE_CTRL, 8'h03);
        plug = 2'b01;
        cyc(5);
        check(st, 8'hfa);
        plug = 2'b00;
        wr(OFS_POWER_MODE_CTRL, 8'h00);
        cyc(5);
    endtask : t_pwr_save

    task automatic t_chip_pd();
        pin_n = 1'b0;
        cyc(4);
        check(st, 8'h01);
        wr(OFS_POWER_MODE_CTRL, {6'h00, MODE_SOFT_PD});
        rd(OFS_SLEEP_DELAY_CFG, 8'h00);
        pin_n = 1'b1;
        cyc(4);
        check(st, 8'hfe);
        rd(OFS_POWER_MODE_CTRL, 8'h00);
    endtask : t_chip_pd

    initial
    begin
        cyc(2);
        rst_i = 1'b0;
        cyc(1);
        t_reset();
        t_port_pd();
        t_soft_pd();
        t_energy();
        t_pwr_save();
        t_chip_pd();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
